// *** verilog/video_luma_scale_audio_ctrl.sv ***
// Control registers and light pixel shaping for the video decoder core
`include "vlsa_cfg.svh"
`default_nettype none
module vlsa_video_ctrl
   import vlsa_pkg::*;
(
   // Clock, reset and enable
   input  wire logic            clock,
   input  wire logic            reset_n,
   input  wire logic            clockEnable,
   // Register port
   input  wire vlsa_bus_type    bus,
   output var  logic [7:0]      readData,
   output var  logic            readValid,
   // Video timing from the pins
   input  wire logic            oddField,
   input  wire logic            fieldStart,
   // Picture statistics from the luma path, same clock
   input  wire logic            majorityBelow3q,
   input  wire logic            majorityBelowHalf,
   input  wire logic            majorityBelow1q,
   input  wire logic            majorityBelowAuto,
   // Pixel stream
   input  wire vlsa_pixel_type  pixIn,
   output var  vlsa_pixel_type  pixOut,
   // Controls toward the rest of the core
   output var  logic [7:0]      gainValue,
   output var  vlsa_vertical_ratio_value_type vertical_ratio_value,
   output var  logic            audioClear
);

   vlsa_state_type state;
   vlsa_state_type next_state;

   // ==========================================================
   // Helper decodes
   function automatic logic [7:0] coreLimit(input logic [1:0] code);
      logic [7:0] lim;
      lim = 8'h00;
      unique case (code)
         2'b00: lim = 8'h00;
         2'b01: lim = `VLSA_CORE_L1;
         2'b10: lim = `VLSA_CORE_L2;
         2'b11: lim = `VLSA_CORE_L3;
      endcase
      return lim;
   endfunction

   function automatic logic [7:0] clampVal(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
      logic [7:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   function automatic vlsa_vertical_ratio_value_type decodeScale(input logic [7:0] hiB,
                                                   input logic [7:0] loB);
      vlsa_vertical_ratio_value_type s;
      s.combOn = hiB[`VLSA_COMB_BIT];
      s.ratio  = {hiB[`VLSA_RATIO_HI_MSB:0], loB};
      if (hiB[`VLSA_INT_BIT]) begin
         s.mode = VLSA_INTERLACED;
      end else if (hiB[`VLSA_ALIGN_BIT]) begin
         s.mode = VLSA_FIELD_ALIGNED;
      end else begin
         s.mode = VLSA_NONINTERLACED;
      end
      return s;
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic       majBelow;
      logic       fieldEdge;
      logic [7:0] lumaCored;
      logic [9:0] gainSum;
      majBelow   = 1'b0;
      fieldEdge  = 1'b0;
      lumaCored  = 8'h00;
      gainSum    = 10'h000;
      next_state = state;

      // Pin inputs pass two flops before use
      next_state.oddMeta   = oddField;
      next_state.oddSync   = state.oddMeta;
      next_state.fieldMeta = fieldStart;
      next_state.fieldSync = state.fieldMeta;
      next_state.fieldLast = state.fieldSync;
      fieldEdge = state.fieldSync & ~state.fieldLast;

      // Register writes; reads answer one cycle later
      next_state.rvalid = 1'b0;
      if (bus.sel && bus.write) begin
         unique case (bus.addr)
            `VLSA_OFS_WC_RAISE:  next_state.wcRaise = bus.wdata;
            `VLSA_OFS_OUT_FMT:   next_state.outFmt  = bus.wdata;
            `VLSA_OFS_E_VS_HIGH: next_state.eVsHigh = bus.wdata;
            `VLSA_OFS_E_VS_LOW:  next_state.eVsLow  = bus.wdata;
            `VLSA_OFS_O_VS_HIGH: next_state.oVsHigh = bus.wdata;
            `VLSA_OFS_O_VS_LOW:  next_state.oVsLow  = bus.wdata;
            // Low bits kept as written; host keeps them zero
            `VLSA_OFS_AUDIO_RST: next_state.audioRst = bus.wdata;
            // Fixed register ignores any write
            default: ;
         endcase
      end else if (bus.sel) begin
         next_state.rvalid = 1'b1;
         unique case (bus.addr)
            `VLSA_OFS_WC_RAISE:  next_state.rdata = state.wcRaise;
            `VLSA_OFS_OUT_FMT:   next_state.rdata = state.outFmt;
            `VLSA_OFS_E_VS_HIGH: next_state.rdata = state.eVsHigh;
            `VLSA_OFS_E_VS_LOW:  next_state.rdata = state.eVsLow;
            `VLSA_OFS_O_VS_HIGH: next_state.rdata = state.oVsHigh;
            `VLSA_OFS_O_VS_LOW:  next_state.rdata = state.oVsLow;
            `VLSA_OFS_AUDIO_RST: next_state.rdata = state.audioRst;
            `VLSA_OFS_FIXED:     next_state.rdata = `VLSA_FIXED_VALUE;
            default:             next_state.rdata = 8'h00;
         endcase
      end

      // Falling edge of the audio bit resets the audio circuitry
      next_state.audioClear = state.audioRst[`VLSA_AUDIO_BIT] &
                              ~next_state.audioRst[`VLSA_AUDIO_BIT];

      // Majority comparison against the selected level
      unique case (state.wcRaise[`VLSA_MAJ_MSB:`VLSA_MAJ_LSB])
         2'b00: majBelow = majorityBelow3q;
         2'b01: majBelow = majorityBelowHalf;
         2'b10: majBelow = majorityBelow1q;
         2'b11: majBelow = majorityBelowAuto;
      endcase

      // Once per field: add unsigned count, raise the gain, saturate
      if (fieldEdge) begin
         if (majBelow) begin
            // Accumulator saturates so a long dark run cannot wrap
            gainSum = {1'b0, state.raiseAccum} +
                      {4'b0000, state.wcRaise[`VLSA_CNT_MSB:0]};
            next_state.raiseAccum = gainSum[9] ? 9'h1FF : gainSum[8:0];
            gainSum = {2'b00, `VLSA_GAIN_INIT} +
                      {1'b0, next_state.raiseAccum};
            next_state.gainValue = gainSum[9:8] != 2'b00 ?
                                   8'hFF : gainSum[7:0];
         end
         // Field copy latched at field start so a field stays whole
         next_state.vertical_ratio_value = state.oddSync ?
            decodeScale(state.oVsHigh, state.oVsLow) :
            decodeScale(state.eVsHigh, state.eVsLow);
      end

      // Coring then range limiting
      lumaCored = pixIn.luma;
      if (pixIn.luma < coreLimit(state.outFmt[`VLSA_CORE_MSB:
                                              `VLSA_CORE_LSB])) begin
         lumaCored = 8'h00;
      end
      if (state.outFmt[`VLSA_RANGE_BIT]) begin
         next_state.pixOut.luma = lumaCored;
      end else begin
         next_state.pixOut.luma = clampVal(lumaCored, `VLSA_LUMA_MIN,
                                           `VLSA_LUMA_MAX);
      end
      next_state.pixOut.cb = clampVal(pixIn.cb, `VLSA_CHROMA_MIN,
                                      `VLSA_CHROMA_MAX);
      next_state.pixOut.cr = clampVal(pixIn.cr, `VLSA_CHROMA_MIN,
                                      `VLSA_CHROMA_MAX);
   end

   // ==========================================================
   // State register; reset loads the documented defaults
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state          <= '0;
         state.wcRaise  <= `VLSA_RST_WC_RAISE;
         state.outFmt   <= `VLSA_RST_OUT_FMT;
         state.eVsHigh  <= `VLSA_RST_VS_HIGH;
         state.oVsHigh  <= `VLSA_RST_VS_HIGH;
         state.eVsLow   <= `VLSA_RST_VS_LOW;
         state.oVsLow   <= `VLSA_RST_VS_LOW;
         state.audioRst <= `VLSA_RST_AUDIO;
         state.gainValue <= `VLSA_GAIN_INIT;
         state.vertical_ratio_value.mode   <= VLSA_INTERLACED;
         state.vertical_ratio_value.combOn <= 1'b1;
      end else if (clockEnable) begin
         state <= next_state;
      end
   end

   // Outputs straight from flops
   assign readData   = state.rdata;
   assign readValid  = state.rvalid;
   assign pixOut     = state.pixOut;
   assign gainValue  = state.gainValue;
   assign vertical_ratio_value     = state.vertical_ratio_value;
   assign audioClear = state.audioClear;

endmodule
`default_nettype wire

// *** inc/vlsa_cfg.svh ***
// Offsets, field positions, reset values and limits of the video control bank
`ifndef VLSA_CFG_SVH
`define VLSA_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define VLSA_OFS_WC_RAISE   8'h44
`define VLSA_OFS_OUT_FMT    8'h48
`define VLSA_OFS_E_VS_HIGH  8'h4C
`define VLSA_OFS_E_VS_LOW   8'h50
`define VLSA_OFS_FIXED      8'h54
`define VLSA_OFS_AUDIO_RST  8'h5B
`define VLSA_OFS_O_VS_HIGH  8'hCC
`define VLSA_OFS_O_VS_LOW   8'hD0

// ==========================================================
// Reset values
`define VLSA_RST_WC_RAISE   8'hCF
`define VLSA_RST_OUT_FMT    8'h00
`define VLSA_RST_VS_HIGH    8'h60
`define VLSA_RST_VS_LOW     8'h00
`define VLSA_RST_AUDIO      8'h00
`define VLSA_FIXED_VALUE    8'h01

// ==========================================================
// Field positions
`define VLSA_MAJ_MSB        7
`define VLSA_MAJ_LSB        6
`define VLSA_CNT_MSB        5
`define VLSA_RANGE_BIT      7
`define VLSA_CORE_MSB       6
`define VLSA_CORE_LSB       5
`define VLSA_ALIGN_BIT      7
`define VLSA_COMB_BIT       6
`define VLSA_INT_BIT        5
`define VLSA_RATIO_HI_MSB   4
`define VLSA_AUDIO_BIT      7

// ==========================================================
// Luma thresholds and output limits
`define VLSA_THR_3Q         8'hBF
`define VLSA_THR_HALF       8'h80
`define VLSA_THR_1Q         8'h40
`define VLSA_LUMA_MIN       8'h10
`define VLSA_LUMA_MAX       8'hFD
`define VLSA_CHROMA_MIN     8'h02
`define VLSA_CHROMA_MAX     8'hFD
`define VLSA_CORE_L1        8'h08
`define VLSA_CORE_L2        8'h10
`define VLSA_CORE_L3        8'h20
`define VLSA_GAIN_INIT      8'h00

`endif

// *** inc/vlsa_pkg.sv ***
// Types shared by the video control bank
`default_nettype none
package vlsa_pkg;

   // Vertical scaling mode decoded from align and interlace bits
   typedef enum logic [1:0] {
      VLSA_NONINTERLACED,
      VLSA_INTERLACED,
      VLSA_FIELD_ALIGNED
   } vlsa_vmode_type;

   // One field's set of vertical scaling controls
   typedef struct packed {
      vlsa_vmode_type mode;
      logic           combOn;
      logic [12:0]    ratio;
   } vlsa_vertical_ratio_value_type;

   // One pixel on the video path
   typedef struct packed {
      logic [7:0] luma;
      logic [7:0] cb;
      logic [7:0] cr;
   } vlsa_pixel_type;

   // Register bus request
   typedef struct packed {
      logic       sel;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vlsa_bus_type;

   // Whole state of the bank
   typedef struct packed {
      logic [7:0]      wcRaise;
      logic [7:0]      outFmt;
      logic [7:0]      eVsHigh;
      logic [7:0]      eVsLow;
      logic [7:0]      oVsHigh;
      logic [7:0]      oVsLow;
      logic [7:0]      audioRst;
      logic [7:0]      rdata;
      logic            rvalid;
      logic            oddMeta;
      logic            oddSync;
      logic            fieldMeta;
      logic            fieldSync;
      logic            fieldLast;
      logic [8:0]      raiseAccum;
      logic [7:0]      gainValue;
      logic            audioClear;
      vlsa_vertical_ratio_value_type vertical_ratio_value;
      vlsa_pixel_type  pixOut;
   } vlsa_state_type;

endpackage
`default_nettype wire

// *** sim/vlsa_video_ctrl_monitor.sv ***
// Port checker for the video control bank
`default_nettype none
module vlsa_video_ctrl_monitor
   import vlsa_pkg::*;
(
   // Clock and reset
   input wire logic            clock,
   input wire logic            reset_n,
   // Register port
   input wire logic            clockEnable,
   input wire vlsa_bus_type    bus,
   input wire logic [7:0]      readData,
   input wire logic            readValid,
   // Field timing and outputs
   input wire logic            fieldStart,
   input wire vlsa_pixel_type  pixOut,
   input wire logic [7:0]      gainValue,
   input wire vlsa_vertical_ratio_value_type vertical_ratio_value,
   input wire logic            audioClear
);
   // ==========================================================
   // One domain, so clock and disable are given once
   default clocking mcb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   logic rdReq;
   logic wrAud;
   // Request decodes shared by several checks
   assign rdReq = clockEnable & bus.sel & !bus.write;
   assign wrAud = clockEnable & bus.sel & bus.write & (bus.addr == 8'h5B);

   // ==========================================================
   // Assertions
   a_read_answers: assert property (rdReq |=> readValid)
      else $error("read not answered");
   a_read_cause: assert property (readValid |-> $past(rdReq))
      else $error("read answer without request");
   a_fixed_reads_one: assert property
      (rdReq && bus.addr == 8'h54 |=> readData == 8'h01)
      else $error("fixed register not 01");
   a_audio_single: assert property (audioClear |=> !audioClear)
      else $error("audio clear longer than one cycle");
   a_audio_cause: assert property
      (audioClear |-> $past(wrAud && !bus.wdata[7]))
      else $error("audio clear without falling write");
   a_gain_rises: assert property (gainValue >= $past(gainValue))
      else $error("gain value fell");
   a_gain_at_field: assert property ($changed(gainValue) |->
      $past(fieldStart, 2) || $past(fieldStart, 3) || $past(fieldStart, 4))
      else $error("gain moved outside field start");
   a_scale_at_field: assert property ($changed(vertical_ratio_value) |->
      $past(fieldStart, 2) || $past(fieldStart, 3) || $past(fieldStart, 4))
      else $error("scale copy moved outside field start");
   a_chroma_limited: assert property ($past(reset_n) |->
      pixOut.cb inside {[8'h02:8'hFD]} && pixOut.cr inside {[8'h02:8'hFD]})
      else $error("chroma outside limits");

   // Main scenarios reached
   c_read: cover property (readValid);
   c_audio: cover property (audioClear);
   c_gain: cover property ($changed(gainValue));
   c_scale: cover property ($changed(vertical_ratio_value));
endmodule

bind vlsa_video_ctrl vlsa_video_ctrl_monitor u_mon (
   .clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
   .bus(bus), .readData(readData), .readValid(readValid),
   .fieldStart(fieldStart), .pixOut(pixOut), .gainValue(gainValue),
   .vertical_ratio_value(vertical_ratio_value), .audioClear(audioClear));
`default_nettype wire

// *** sim/video_luma_scale_audio_ctrl_tb.sv ***
// Self-checking bench for the video control bank
`default_nettype none
module video_luma_scale_audio_ctrl_tb
   import vlsa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic            clock, reset_n, clockEnable, oddField, fieldStart;
   logic            majorityBelow3q, majorityBelowHalf;
   logic            majorityBelow1q, majorityBelowAuto;
   vlsa_bus_type    bus;
   vlsa_pixel_type  pixIn, pixOut;
   vlsa_vertical_ratio_value_type vertical_ratio_value;
   logic [7:0]      readData, gainValue, lim, expGain;
   logic            readValid, audioClear;
   int              nFail, samplesChecked, n;
   logic [7:0]      ra [8] = '{8'h44, 8'h48, 8'h4C, 8'h50,
                               8'h54, 8'h5B, 8'hCC, 8'hD0};
   logic [7:0]      rv [8] = '{8'hCF, 8'h00, 8'h60, 8'h00,
                               8'h01, 8'h00, 8'h60, 8'h00};

   vlsa_video_ctrl u_dut (.clock, .reset_n, .clockEnable, .bus, .readData,
      .readValid, .oddField, .fieldStart, .majorityBelow3q,
      .majorityBelowHalf, .majorityBelow1q, .majorityBelowAuto, .pixIn,
      .pixOut, .gainValue, .vertical_ratio_value, .audioClear);

   // ==========================================================
   // Clock and hang guard
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      #2000000;
      nFail++;
      finalReport();
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      samplesChecked++;
      if (got !== exp) begin
         nFail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      bus <= '{1'b1, 1'b1, a, d};
      @(posedge clock);
      bus.sel <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clock);
      bus <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge clock);
      bus.sel <= 1'b0;
      #1;
      chk("readValid", 16'h1, {15'h0, readValid});
      chk("readData", {8'h0, e}, {8'h0, readData});
   endtask
   task automatic px(logic [7:0] f, y, c, ey, ec);
      wr(8'h48, f);
      @(posedge clock);
      pixIn <= '{y, c, c};
      @(posedge clock);
      #1;
      chk("luma", {8'h0, ey}, {8'h0, pixOut.luma});
      chk("chroma", {8'h0, ec}, {8'h0, pixOut.cb});
      chk("chromaCr", {8'h0, ec}, {8'h0, pixOut.cr});
   endtask
   // Field flag settles through its synchroniser before the start edge
   task automatic fld(logic odd);
      @(posedge clock);
      oddField <= odd;
      repeat (3) @(posedge clock);
      fieldStart <= 1'b1;
      repeat (2) @(posedge clock);
      fieldStart <= 1'b0;
      repeat (6) @(posedge clock);
      #1;
   endtask
   task automatic pulses();
      n = 0;
      // Pulse rises at the edge that takes the write, so look there first
      repeat (4) begin
         #1;
         if (audioClear === 1'b1) n++;
         @(posedge clock);
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic tRegs();
      for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
      // Fixed register only ever gets 0x01; audio register left alone
      for (int i = 0; i < 8; i++) begin
         if (i == 4) wr(ra[i], 8'h01);
         else if (i != 5) wr(ra[i], 8'hA0 | 8'(i));
      end
      for (int i = 0; i < 8; i++) begin
         if (i == 4) rd(ra[i], 8'h01);
         else if (i != 5) rd(ra[i], 8'hA0 | 8'(i));
      end
      rd(8'h00, 8'h00);
      $display("test registers done");
   endtask
   task automatic tPixel();
      px(8'h00, 8'h00, 8'h00, 8'h10, 8'h02);
      px(8'h00, 8'hFF, 8'hFF, 8'hFD, 8'hFD);
      px(8'h80, 8'h00, 8'h80, 8'h00, 8'h80);
      px(8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFD);
      px(8'h80, 8'h01, 8'h80, 8'h01, 8'h80);
      for (int k = 1; k < 4; k++) begin
         lim = 8'h04 << k;
         px({1'b1, k[1:0], 5'h00}, lim - 8'h01,
            8'h80, 8'h00, 8'h80);
         px({1'b1, k[1:0], 5'h00}, lim, 8'h80, lim, 8'h80);
      end
      $display("test pixel done");
   endtask
   task automatic tGain();
      expGain = 8'h00;
      for (int k = 0; k < 4; k++) begin
         wr(8'h44, {k[1:0], 6'h05});
         {majorityBelow3q, majorityBelowHalf, majorityBelow1q,
          majorityBelowAuto} <= 4'h8 >> k;
         fld(1'b0);
         expGain = expGain + 8'h05;
         chk("gain", {8'h0, expGain}, {8'h0, gainValue});
      end
      wr(8'h44, 8'h3F);
      fld(1'b0);
      chk("gain", {8'h0, expGain}, {8'h0, gainValue});
      wr(8'h44, 8'hFF);
      fld(1'b0);
      chk("gain", 16'h0053, {8'h0, gainValue});
      repeat (3) fld(1'b0);
      chk("gain", 16'h00FF, {8'h0, gainValue});
      {majorityBelow3q, majorityBelowHalf, majorityBelow1q,
       majorityBelowAuto} <= 4'h0;
      $display("test gain done");
   endtask
   task automatic tScale();
      logic [16:0] v;
      wr(8'h4C, 8'h95);
      wr(8'h50, 8'h3C);
      wr(8'hCC, 8'h63);
      wr(8'hD0, 8'hC3);
      fld(1'b0);
      chk("vertical_ratio_value", {VLSA_FIELD_ALIGNED, 1'b0, 13'h153C},
          vertical_ratio_value);
      fld(1'b1);
      chk("vertical_ratio_value", {VLSA_INTERLACED, 1'b1, 13'h03C3}, vertical_ratio_value);
      wr(8'hCC, 8'h00);
      fld(1'b1);
      chk("vertical_ratio_value", {VLSA_NONINTERLACED, 1'b0, 13'h00C3}, vertical_ratio_value);
      wr(8'hCC, 8'hA0);
      fld(1'b1);
      chk("vertical_ratio_value", {VLSA_INTERLACED, 1'b0, 13'h00C3}, vertical_ratio_value);
      // Ratio of two programmed through the software formula
      v = 17'h10000 - 17'h00200 + 17'h01FFF;
      wr(8'h4C, {3'b011, v[12:8]});
      wr(8'h50, v[7:0]);
      fld(1'b0);
      chk("vertical_ratio_value", {VLSA_INTERLACED, 1'b1, 13'h1DFF}, vertical_ratio_value);
      $display("test scale done");
   endtask
   task automatic tAudio();
      wr(8'h5B, 8'h80);
      wr(8'h5B, 8'h00);
      pulses();
      chk("audioClear", 16'h1, n[15:0]);
      wr(8'h5B, 8'h00);
      pulses();
      chk("audioClear", 16'h0, n[15:0]);
      rd(8'h5B, 8'h00);
      $display("test audio done");
   endtask
   // Write while disabled must not land
   task automatic tFreeze();
      @(posedge clock);
      clockEnable <= 1'b0;
      wr(8'h44, 8'h11);
      @(posedge clock);
      clockEnable <= 1'b1;
      rd(8'h44, 8'hFF);
      $display("test freeze done");
   endtask

   task automatic finalReport();
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {reset_n, oddField, fieldStart, majorityBelow3q, majorityBelowHalf,
       majorityBelow1q, majorityBelowAuto} = '0;
      clockEnable = 1'b1;
      bus = '0;
      pixIn = '0;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      tRegs();
      tPixel();
      tGain();
      tScale();
      tAudio();
      tFreeze();
      finalReport();
   end
endmodule
`default_nettype wire
